// *** core/tmq_map.svh ***
`ifndef TMQ_MAP_SVH
`define TMQ_MAP_SVH
// Register byte addresses
`define TMQ_ADDR_RUN 32'hfffff540
`define TMQ_ADDR_MODE 32'hfffff541
`define TMQ_ADDR_OUT 32'hfffff542
`define TMQ_ADDR_CNT 32'hfffff54c
`define TMQ_ADDR_OVF 32'hfffff545
// Field positions and masks
`define TMQ_RUN_EN_BIT 7
`define TMQ_RUN_MASK 8'h87
`define TMQ_MODE_TRIG_BIT 6
`define TMQ_MODE_EEE_BIT 5
`define TMQ_MODE_MASK 8'h27
`define TMQ_OVF_MASK 8'h01
`define TMQ_OVF_BIT 0
`define TMQ_RUN_CKS_MSB 2
`define TMQ_RUN_CKS_LSB 0
`define TMQ_MODE_MD_MSB 2
`define TMQ_MODE_MD_LSB 0
`define TMQ_REG_RESET 8'h00
`define TMQ_CNT_IDLE 16'hffff
`define TMQ_CNT_ZERO 16'h0000
`endif

// *** core/tmq_pkg.sv ***
package tmq_pkg;
	typedef enum logic [2:0] {
		TMQ_MODE_INTERVAL = 3'h0,
		TMQ_MODE_EVENT = 3'h1,
		TMQ_MODE_EXT_PULSE = 3'h2,
		TMQ_MODE_ONE_SHOT = 3'h3,
		TMQ_MODE_PWM = 3'h4,
		TMQ_MODE_FREE_RUN = 3'h5,
		TMQ_MODE_PULSE_MEAS = 3'h6,
		TMQ_MODE_BAD = 3'h7
	} tmq_mode_t;
	typedef enum logic [1:0] {
		TMQ_WB_IDLE = 2'b00,
		TMQ_WB_ACK = 2'b01
	} tmq_wb_state_t;
endpackage

// *** core/tmq_timer_ctrl.sv ***
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/100ps
`include "tmq_map.svh"
//
// Contract
// - Run-control register at fffff540, bits 7 and 2-0 read/write, others read zero, reset to zero.
// - All three control registers accept whole-byte or single-bit access.
// - Enable bit clear stops and resets timer; setting it starts timer.
// - Disabled timer clears overflow flag and the square wave of all four outputs, and sets the counter to all ones.
// - Three-bit clock select divides main clock by 1 through 128 ascending.
// - Clock select written together with enable 0-to-1 applies at once.
// - Rewriting run-control with same value has no side effect.
// - Mode-control at fffff541: trigger bit 6, event enable bit 5, mode bits 2-0.
// - Software trigger acts as external trigger in one-shot or trigger-pulse mode.
// - Software trigger ignored in all other modes.
// - Event enable 0 counts internal clock, 1 counts external event edges.
// - Mode codes 0-6: interval, event, trigger pulse, one-shot, PWM, free-run, measure.
// - Event count mode counts external edges regardless of event enable.
// - Output-control at fffff542: channel m enable at 2m, invert at 2m+1.
// - Invert bit 1 inverts the pin level; 0 leaves it as is.
// - Output disabled drives low, or high when inverted.
// - Output enabled drives the timer square wave.
// - Invert bit changes pin level at once, even with everything disabled.
// - Disabled counter holds all ones but reads back as zero.
// - Overflow flag clears on software write of 0 or enable bit 0.
//
module tmq_timer_ctrl #(
	parameter int PRESCALE_W = 7,
	parameter int CNT_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic event_trigger_input_pin_i,
	output logic [3:0] timer_output_pin_o,
	output logic [2:0] active_mode_o,
	output logic count_tick_o,
	output logic trigger_pulse_o
);
	import tmq_pkg::*;

	// Prescaler taps and read lanes are laid out for these sizes only
	if (PRESCALE_W != 7 || CNT_W != 16) begin : g_bad_size
		$error("tmq_timer_ctrl: prescaler must be 7 bits and counter 16 bits");
	end

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	logic [7:0] run_control_reg;
	logic [7:0] mode_control_reg;
	logic [7:0] output_control_reg;
	logic overflow_flag;
	logic [CNT_W-1:0] counter;
	tmq_wb_state_t wb_state;
	tmq_wb_state_t next_wb_state;
	logic [31:0] next_rdata;
	logic wb_req;
	logic wr_run;
	logic wr_mode;
	logic wr_out;
	logic wr_ovf;
	logic [7:0] wr_byte;
	logic [7:0] next_run;
	logic timer_enable_bit;
	logic [2:0] clock_select;
	tmq_mode_t mode;
	logic event_count_enable_bit;

	// Byte lane picked from the low address bits, so single-byte and bit writes work
	assign wb_req = wb_cyc_i && wb_stb_i && (wb_state == TMQ_WB_IDLE);
	always_comb begin
		case (wb_adr_i[1:0])
			2'h0: wr_byte = wb_dat_i[7:0];
			2'h1: wr_byte = wb_dat_i[15:8];
			2'h2: wr_byte = wb_dat_i[23:16];
			default: wr_byte = wb_dat_i[31:24];
		endcase
	end
	function automatic logic lane_on(input logic [1:0] a, input logic [3:0] sel);
		lane_on = sel[a];
	endfunction
	assign wr_run = wb_req && wb_we_i && wb_adr_i == `TMQ_ADDR_RUN && lane_on(wb_adr_i[1:0], wb_sel_i);
	assign wr_mode = wb_req && wb_we_i && wb_adr_i == `TMQ_ADDR_MODE && lane_on(wb_adr_i[1:0], wb_sel_i);
	assign wr_out = wb_req && wb_we_i && wb_adr_i == `TMQ_ADDR_OUT && lane_on(wb_adr_i[1:0], wb_sel_i);
	assign wr_ovf = wb_req && wb_we_i && wb_adr_i == `TMQ_ADDR_OVF && lane_on(wb_adr_i[1:0], wb_sel_i);
	assign next_run = wr_byte & `TMQ_RUN_MASK;

	// Requests are ignored in the ack state, so a strobe held while ack is high is not taken twice
	always_comb begin
		next_wb_state = wb_state;
		case (wb_state)
			TMQ_WB_IDLE: begin
				if (wb_cyc_i && wb_stb_i) begin
					next_wb_state = TMQ_WB_ACK;
				end
			end
			TMQ_WB_ACK: begin
				next_wb_state = TMQ_WB_IDLE;
			end
			default: begin
				next_wb_state = TMQ_WB_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_state <= TMQ_WB_IDLE;
			wb_ack_o <= 1'b0;
		end else begin
			wb_state <= next_wb_state;
			wb_ack_o <= next_wb_state == TMQ_WB_ACK;
		end
	end

	// Read data placed on the lane of the byte address; unmapped reads zero
	always_comb begin
		case (wb_adr_i)
			`TMQ_ADDR_RUN: next_rdata = {24'h00_0000, run_control_reg};
			`TMQ_ADDR_MODE: next_rdata = {16'h0000, mode_control_reg, 8'h00};
			`TMQ_ADDR_OUT: next_rdata = {8'h00, output_control_reg, 16'h0000};
			`TMQ_ADDR_OVF: next_rdata = {16'h0000, 7'h00, overflow_flag, 8'h00};
			// Idle counter sits at all ones yet must read as zero
			`TMQ_ADDR_CNT: next_rdata = {16'h0000, timer_enable_bit ? counter : `TMQ_CNT_ZERO};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_req && !wb_we_i) begin
			wb_dat_o <= next_rdata;
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_control_reg <= `TMQ_REG_RESET;
		end else if (wr_run) begin
			// Clock select and enable land together; same-value write changes nothing
			run_control_reg <= next_run;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_control_reg <= `TMQ_REG_RESET;
		end else if (wr_mode) begin
			// Trigger bit is a strobe and never stored
			mode_control_reg <= wr_byte & `TMQ_MODE_MASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			output_control_reg <= `TMQ_REG_RESET;
		end else if (wr_out) begin
			output_control_reg <= wr_byte;
		end
	end

	assign timer_enable_bit = run_control_reg[`TMQ_RUN_EN_BIT];
	assign clock_select = run_control_reg[`TMQ_RUN_CKS_MSB:`TMQ_RUN_CKS_LSB];
	assign mode = tmq_mode_t'(mode_control_reg[`TMQ_MODE_MD_MSB:`TMQ_MODE_MD_LSB]);
	assign event_count_enable_bit = mode_control_reg[`TMQ_MODE_EEE_BIT];

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	logic mode_counts_events;
	logic mode_takes_trigger;
	logic mode_flags_overflow;

	// Prohibited code 7 falls to the default branch and counts like the interval timer
	always_comb begin
		mode_counts_events = 1'b0;
		mode_takes_trigger = 1'b0;
		mode_flags_overflow = 1'b0;
		case (mode)
			TMQ_MODE_INTERVAL: begin
				mode_counts_events = 1'b0;
			end
			TMQ_MODE_EVENT: begin
				mode_counts_events = 1'b1;
			end
			TMQ_MODE_EXT_PULSE: begin
				mode_takes_trigger = 1'b1;
			end
			TMQ_MODE_ONE_SHOT: begin
				mode_takes_trigger = 1'b1;
			end
			TMQ_MODE_PWM: begin
				mode_takes_trigger = 1'b0;
			end
			TMQ_MODE_FREE_RUN: begin
				mode_flags_overflow = 1'b1;
			end
			TMQ_MODE_PULSE_MEAS: begin
				mode_flags_overflow = 1'b1;
			end
			default: begin
				mode_counts_events = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Prescaler and count enable
	// ----------------------------------------
	logic [PRESCALE_W-1:0] prescale;
	logic [PRESCALE_W:0] tap;
	logic internal_tick;
	logic [2:0] evt_sync;
	logic evt_edge;
	logic evt_level;
	logic count_en;

	// Free divider restarts with the timer so the first tick is a full period
	always_ff @(posedge clk_i) begin
		if (rst_i || !timer_enable_bit) begin
			prescale <= '0;
		end else begin
			prescale <= prescale + 1'b1;
		end
	end

	genvar gi;
	assign tap[0] = 1'b1;
	generate
		for (gi = 1; gi <= PRESCALE_W; gi++) begin : g_tap
			assign tap[gi] = &prescale[gi-1:0];
		end
	endgenerate
	assign internal_tick = tap[clock_select];

	// Three-stage sync; a rising edge counts once stages two and three both read high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_sync <= 3'h0;
		end else begin
			evt_sync <= {evt_sync[1:0], event_trigger_input_pin_i};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_level <= 1'b0;
		end else if (evt_sync[1] == evt_sync[2]) begin
			evt_level <= evt_sync[2];
		end
	end
	assign evt_edge = evt_sync[2] && evt_sync[1] && !evt_level;

	always_comb begin
		if (mode_counts_events || event_count_enable_bit) begin
			count_en = evt_edge;
		end else begin
			count_en = internal_tick;
		end
	end

	// ----------------------------------------
	// Counter, overflow, trigger
	// ----------------------------------------
	logic sw_trigger;
	logic [3:0] square;
	logic cnt_started;
	logic cnt_wrap;

	// First count after enable only leaves the all-ones idle value; no wrap there
	always_ff @(posedge clk_i) begin
		if (rst_i || !timer_enable_bit) begin
			cnt_started <= 1'b0;
		end else if (count_en) begin
			cnt_started <= 1'b1;
		end
	end
	assign cnt_wrap = count_en && cnt_started && counter == `TMQ_CNT_IDLE;

	always_ff @(posedge clk_i) begin
		if (rst_i || !timer_enable_bit) begin
			counter <= `TMQ_CNT_IDLE;
		end else if (count_en) begin
			counter <= counter + 1'b1;
		end
	end

	// Overflow set wins over a software clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i || !timer_enable_bit) begin
			overflow_flag <= 1'b0;
		end else if (cnt_wrap && mode_flags_overflow) begin
			overflow_flag <= 1'b1;
		end else if (wr_ovf && !wr_byte[`TMQ_OVF_BIT]) begin
			overflow_flag <= 1'b0;
		end
	end

	assign sw_trigger = wr_mode && wr_byte[`TMQ_MODE_TRIG_BIT] && timer_enable_bit
		&& mode_takes_trigger;

	// Trigger only visible as a pulse; the pulse generators sit outside this block
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trigger_pulse_o <= 1'b0;
		end else begin
			trigger_pulse_o <= sw_trigger;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_tick_o <= 1'b0;
		end else begin
			count_tick_o <= count_en && timer_enable_bit;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_mode_o <= 3'h0;
		end else begin
			active_mode_o <= mode_control_reg[`TMQ_MODE_MD_MSB:`TMQ_MODE_MD_LSB];
		end
	end

	// ----------------------------------------
	// Output control
	// ----------------------------------------
	// Square wave toggles on counter wrap; detailed per-mode waveform lives elsewhere
	always_ff @(posedge clk_i) begin
		if (rst_i || !timer_enable_bit) begin
			square <= 4'h0;
		end else if (cnt_wrap) begin
			square <= ~square;
		end
	end

	// Pin register follows invert bit immediately, even when disabled
	logic [3:0] next_pin;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin
			assign next_pin[gi] = (output_control_reg[2*gi] & square[gi])
				^ output_control_reg[2*gi+1];
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_output_pin_o <= 4'h0;
		end else begin
			timer_output_pin_o <= next_pin;
		end
	end
endmodule

// *** dv/tmq_assertions.sv ***
`timescale 1ns/100ps
`include "tmq_map.svh"
module tmq_assertions (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [3:0] timer_output_pin_o,
	input wire logic [2:0] active_mode_o,
	input wire logic trigger_pulse_o
);
	// ----
	// Bus and pin checks
	// ----
	logic rd;
	logic wr;
	logic [3:0] inv_bits;
	logic [2:0] mode_bits;
	assign rd = wb_ack_o && !wb_we_i;
	assign wr = wb_ack_o && wb_we_i;
	assign inv_bits = {wb_dat_i[23], wb_dat_i[21], wb_dat_i[19], wb_dat_i[17]};
	assign mode_bits = wb_dat_i[10:8];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
	AST_ACK_ONCE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	AST_RUN_RSV: assert property (rd && wb_adr_i == `TMQ_ADDR_RUN |-> wb_dat_o[6:3] == 4'h0) else $error("run rsv");
	AST_MODE_RSV: assert property (rd && wb_adr_i == `TMQ_ADDR_MODE |-> (wb_dat_o[15:8] & 8'hd8) == 8'h00)
		else $error("mode rsv");
	AST_UNMAP: assert property (rd && !(wb_adr_i inside {`TMQ_ADDR_RUN, `TMQ_ADDR_MODE, `TMQ_ADDR_OUT,
		`TMQ_ADDR_CNT, `TMQ_ADDR_OVF}) |-> wb_dat_o == 32'h0) else $error("unmapped data");
	AST_TRIG_MODE: assert property (trigger_pulse_o |-> active_mode_o inside {3'h2, 3'h3})
		else $error("bad trigger");
	AST_PIN_LVL: assert property (wr && wb_adr_i == `TMQ_ADDR_OUT && wb_sel_i[2]
		&& (wb_dat_i[23:16] & 8'h55) == 8'h00 |-> ##2 timer_output_pin_o == $past(inv_bits, 2))
		else $error("pin level");
	AST_MODE_OUT: assert property (wr && wb_adr_i == `TMQ_ADDR_MODE && wb_sel_i[1]
		|-> ##2 active_mode_o == $past(mode_bits, 2)) else $error("mode out");
	cover property (trigger_pulse_o);
	cover property (rd && wb_adr_i == `TMQ_ADDR_CNT);
	cover property (wr && wb_adr_i == `TMQ_ADDR_OUT);
endmodule
bind tmq_timer_ctrl tmq_assertions u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
	.wb_sel_i, .wb_dat_o, .wb_ack_o, .timer_output_pin_o, .active_mode_o, .trigger_pulse_o);

// *** dv/tmq_event_src.sv ***
`timescale 1ns/100ps
module tmq_event_src (
	input wire logic clk_i,
	output logic event_trigger_input_pin_o
);
	// Wide pulses so the synchroniser never misses one
	initial event_trigger_input_pin_o = 1'b0;
	task automatic send(input int n);
		repeat (n) begin
			@(posedge clk_i) event_trigger_input_pin_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			event_trigger_input_pin_o <= 1'b0;
			repeat (4) @(posedge clk_i);
		end
	endtask
endmodule

// *** dv/timer16_mode_and_output_control_tb.sv ***
`timescale 1ns/100ps
`include "tmq_map.svh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fails++; \
	$display("unexpected %s exp %h got %h", n, e, a); end end
module timer16_mode_and_output_control_tb;
	import tmq_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic [31:0] adr = 0, wdat = 0, rdat, dat_o;
	logic [3:0] sel = 0, pins;
	logic ack, ev, tick, trg;
	logic [2:0] md;
	int fails = 0, cmp_count = 0, ticks = 0, trgs = 0, t0;
	initial forever #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		ticks <= ticks + (tick === 1'b1);
		trgs <= trgs + (trg === 1'b1);
	end
	tmq_timer_ctrl u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack), .event_trigger_input_pin_i(ev),
		.timer_output_pin_o(pins), .active_mode_o(md), .count_tick_o(tick), .trigger_pulse_o(trg));
	tmq_event_src u_src (.clk_i, .event_trigger_input_pin_o(ev));
	// ----
	// Bus access
	// ----
	task automatic acc(input logic w, input logic [31:0] a, input logic [7:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {4{d}};
		sel <= 4'h1 << a[1:0];
		@(posedge clk_i);
		while (ack !== 1'b1) begin
			@(posedge clk_i);
		end
		rdat = dat_o >> (8 * a[1:0]);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rw(input logic [31:0] a, input logic [7:0] w, input logic [7:0] e);
		acc(0, a, 8'h00);
		`CHK("reset", 8'h00, rdat[7:0]);
		acc(1, a, w);
		acc(0, a, 8'h00);
		`CHK("readback", e, rdat[7:0]);
	endtask
	task give_verdict;
		$display("fails=%0d compares=%0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#900000;
		fails++;
		give_verdict;
	end
	// ----
	// Tests
	// ----
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		rw(`TMQ_ADDR_RUN, 8'h07, 8'h07);
		rw(`TMQ_ADDR_MODE, 8'h66, 8'h26);
		rw(`TMQ_ADDR_OUT, 8'hff, 8'hff);
		acc(0, `TMQ_ADDR_CNT, 8'h00);
		`CHK("count", 16'h0000, rdat[15:0]);
		acc(0, 32'hfffff548, 8'h00);
		`CHK("unmapped", 8'h00, rdat[7:0]);
		acc(1, `TMQ_ADDR_OUT, 8'haa);
		@(posedge clk_i);
		`CHK("pins", 4'hf, pins);
		acc(1, `TMQ_ADDR_OUT, 8'h00);
		@(posedge clk_i);
		`CHK("pins", 4'h0, pins);
		acc(1, `TMQ_ADDR_MODE, 8'h00);
		for (int c = 0; c < 8; c++) begin
			acc(1, `TMQ_ADDR_RUN, 8'(c) | 8'h80);
			t0 = ticks;
			repeat (100) @(posedge clk_i);
			acc(1, `TMQ_ADDR_RUN, 8'(c) | 8'h80);
			repeat (153) @(posedge clk_i);
			`CHK("ticks", 256 >> c, ticks - t0);
			acc(1, `TMQ_ADDR_RUN, 8'h00);
		end
		for (int e = 0; e < 2; e++) begin
			acc(1, `TMQ_ADDR_MODE, e ? 8'h20 : 8'h01);
			acc(1, `TMQ_ADDR_RUN, 8'h87);
			t0 = ticks;
			u_src.send(5);
			repeat (8) @(posedge clk_i);
			`CHK("events", 5, ticks - t0);
			acc(1, `TMQ_ADDR_RUN, 8'h00);
		end
		for (int m = 0; m < 7; m++) begin
			acc(1, `TMQ_ADDR_MODE, 8'(m));
			acc(1, `TMQ_ADDR_RUN, 8'h80);
			t0 = trgs;
			acc(1, `TMQ_ADDR_MODE, 8'(m) | 8'h40);
			repeat (4) @(posedge clk_i);
			`CHK("trigger", int'(m == 2 || m == 3), trgs - t0);
			`CHK("mode", 3'(m), md);
			acc(1, `TMQ_ADDR_RUN, 8'h00);
		end
		acc(1, `TMQ_ADDR_OUT, 8'h01);
		acc(1, `TMQ_ADDR_MODE, 8'h05);
		acc(1, `TMQ_ADDR_RUN, 8'h80);
		acc(0, `TMQ_ADDR_OVF, 8'h00);
		`CHK("ovf start", 8'h00, rdat[7:0]);
		`CHK("pin start", 4'h0, pins);
		repeat (65540) @(posedge clk_i);
		acc(0, `TMQ_ADDR_OVF, 8'h00);
		`CHK("ovf set", 8'h01, rdat[7:0]);
		`CHK("pin wave", 4'h1, pins);
		acc(1, `TMQ_ADDR_OVF, 8'h00);
		acc(0, `TMQ_ADDR_OVF, 8'h00);
		`CHK("ovf clear", 8'h00, rdat[7:0]);
		acc(1, `TMQ_ADDR_RUN, 8'h00);
		@(posedge clk_i);
		`CHK("pin stop", 4'h0, pins);
		give_verdict;
	end
endmodule
